// ---- rtl/adcsr_fifo.sv ----
// sample fifo between digitiser core and readout
`timescale 1ns/1ns
module adcsr_fifo
  import adcsr_pkg::*;
#(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  logic             sys_clk,
  input  logic             nrst,
  // fill side
  input  logic [WIDTH-1:0] inData,
  input  logic             inValid,
  output logic             inReady,
  // drain side
  output logic [WIDTH-1:0] outData,
  output logic             outValid,
  input  logic             outReady
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [PW:0]      count;
  logic [PW-1:0]    next_wrPtr;
  logic [PW-1:0]    next_rdPtr;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] bumpPtr(input logic [PW-1:0] p);
    bumpPtr = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  assign inReady  = (count != FULL_CNT);
  assign outValid = (count != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr];

  always_comb begin
    next_wrPtr = push ? bumpPtr(wrPtr) : wrPtr;
    next_rdPtr = pop ? bumpPtr(rdPtr) : rdPtr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      if (push) begin
        mem[wrPtr] <= inData;
      end
    end
  end

endmodule

// ---- rtl/adcsr_pin_sync.sv ----
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ns
module adcsr_pin_sync
  import adcsr_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  logic             sys_clk,
  input  logic             nrst,
  // asynchronous pins
  input  logic [WIDTH-1:0] pinAsync,
  // synchronised view
  output logic [WIDTH-1:0] lvl,
  output logic [WIDTH-1:0] prev,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] last;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;
  logic [WIDTH-1:0] next_last;

  always_comb begin
    next_meta = pinAsync;
    next_sync = meta;
    next_last = sync;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta <= '0;
      sync <= '0;
      last <= '0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      last <= next_last;
    end
  end

  assign lvl  = sync;
  assign prev = last;
  assign rise = sync & ~last;
  assign fall = ~sync & last;

endmodule

// ---- rtl/adcsr_pkg.sv ----
// constants, types and states of the adc serial readout block
// Overview of operation
// - select level at strobe rise picks mode
// - select tied to strobe always gives chain
// - optional start bit ahead of result bits
// - select mode busy if strobe/select low
// - chain busy if serial clock high
// - strobe rise starts conversion, output released
// - conversion ignores later strobe changes
// - after conversion return to powered-down acquisition
// - strobe fall shows msb, clock falls shift
// - each bit stable across the rising clock edge
// - release after 18th fall in select mode, or strobe rise
// - output released throughout the conversion
// - select-mode busy start bit driven low when conversion completes
// - after start bit shift msb first
// - three wires suffice, select line optional
// - 18-bit result: two's complement in range, 2ffff above it, 20000 below it
// - select-mode busy frame released after 19th fall
// - conversion timed by internal clock only
package adcsr_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int RESULT_W        = 18;
  localparam int RAW_W           = 20;
  localparam int SHREG_W         = 19;
  localparam int FIFO_DEPTH      = 4;
  localparam int CNT_W           = 10;
  localparam int BIT_CNT_W       = 5;

  // ----------------------------------------------------------------
  // frame lengths in serial clock falls
  // ----------------------------------------------------------------
  localparam logic [BIT_CNT_W-1:0] FRAME_BITS      = 5'h12;
  localparam logic [BIT_CNT_W-1:0] BUSY_FRAME_BITS = 5'h13;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT        = 5'h01;

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 4;
  localparam int CONV_MIN_NS     = 1000;
  localparam int CONV_TYP_NS     = 2000;
  localparam int CONV_MAX_NS     = 2500;
  localparam int CONV_MIN_CYC    =
    (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TYP_CYC    =
    (CONV_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC    = CONV_MAX_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // output codes and limits
  // ----------------------------------------------------------------
  localparam logic [RESULT_W-1:0]     SAT_POS_CODE  = 18'h2ffff;
  localparam logic [RESULT_W-1:0]     SAT_NEG_CODE  = 18'h20000;
  localparam logic signed [RAW_W-1:0] RAW_POS_LIMIT = 20'sh1ffff;
  localparam logic signed [RAW_W-1:0] RAW_NEG_LIMIT = 20'she0000;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [SHREG_W-1:0]   RST_SHREG     = 19'h00000;
  localparam logic [CNT_W-1:0]     RST_CONV_CNT  = 10'h000;
  localparam logic [BIT_CNT_W-1:0] RST_BITS      = 5'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_CONV  = 4'b0010,
    S_WAIT  = 4'b0100,
    S_SHIFT = 4'b1000
  } adcsr_state_type;

  typedef struct packed {
    logic convertStrobe;
    logic serialClk;
    logic serialInSelect;
  } adcsr_pins_type;

  typedef struct packed {
    logic serialResultOut;
    logic serialResultOeN;
  } adcsr_sdo_type;

endpackage

// ---- rtl/adcsr_top.sv ----
// conversion control and serial result readout
`timescale 1ns/1ns
module adcsr_top
  import adcsr_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_TYP_CYC,
  parameter int DEPTH       = FIFO_DEPTH
) (
  // clock and reset
  input  logic                 sys_clk,
  input  logic                 nrst,
  // serial pins
  input  adcsr_pins_type       pinIn,
  output adcsr_sdo_type        sdoPin,
  // digitiser sample stream
  input  logic [RAW_W-1:0]     sampleData,
  input  logic                 sampleValid,
  output logic                 sampleReady,
  // status
  output logic                 powerDown,
  output logic                 chainMode,
  output logic                 busyEnable
);

  // ----------------------------------------------------------------
  // conversion length, held inside its bounds
  // ----------------------------------------------------------------
  function automatic int clampLen(input int n);
    if (n < CONV_MIN_CYC) begin
      clampLen = CONV_MIN_CYC;
    end else if (n > CONV_MAX_CYC) begin
      clampLen = CONV_MAX_CYC;
    end else begin
      clampLen = n;
    end
  endfunction

  localparam logic [CNT_W-1:0] CONV_LEN =
    CNT_W'(clampLen(CONV_CYCLES));

  // ----------------------------------------------------------------
  // raw sample to output code
  // ----------------------------------------------------------------
  function automatic logic [RESULT_W-1:0] saturate(
    input logic signed [RAW_W-1:0] raw
  );
    if (raw > RAW_POS_LIMIT) begin
      saturate = SAT_POS_CODE;
    end else if (raw < RAW_NEG_LIMIT) begin
      saturate = SAT_NEG_CODE;
    end else begin
      saturate = raw[RESULT_W-1:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and sample fifo
  // ----------------------------------------------------------------
  adcsr_pins_type   pinLvl;
  adcsr_pins_type   pinPrev;
  adcsr_pins_type   pinRise;
  adcsr_pins_type   pinFall;
  logic [RAW_W-1:0] fifoData;
  logic             fifoValid;
  logic             fifoPop;

  adcsr_pin_sync #(
    .WIDTH ($bits(adcsr_pins_type))
  ) u_sync (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .pinAsync (pinIn),
    .lvl      (pinLvl),
    .prev     (pinPrev),
    .rise     (pinRise),
    .fall     (pinFall)
  );

  adcsr_fifo #(
    .WIDTH (RAW_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .inData   (sampleData),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  adcsr_state_type      state;
  adcsr_state_type      next_state;
  logic [CNT_W-1:0]     convCnt;
  logic [CNT_W-1:0]     next_convCnt;
  logic [SHREG_W-1:0]   shReg;
  logic [SHREG_W-1:0]   next_shReg;
  logic [BIT_CNT_W-1:0] bitsLeft;
  logic [BIT_CNT_W-1:0] next_bitsLeft;
  logic                 next_chainMode;
  logic                 next_busyEnable;
  adcsr_sdo_type        next_sdoPin;
  logic                 next_powerDown;
  logic                 startConv;
  logic                 endBusy;
  logic                 csBusy;
  logic                 readSelect;
  logic                 sclkFall;
  logic                 sdiRise;

  // a rising strobe is only heard outside a conversion
  assign startConv  = pinRise.convertStrobe && (state != S_CONV);
  // busy in select mode is judged on the levels at the end
  assign csBusy     = !pinLvl.convertStrobe ||
                      !pinLvl.serialInSelect;
  assign endBusy    = chainMode ? busyEnable : csBusy;
  // strobe low on three wires, select low on four
  assign readSelect = !pinLvl.convertStrobe ||
                      !pinLvl.serialInSelect;
  assign sclkFall   = pinFall.serialClk;
  assign sdiRise    = pinRise.serialInSelect && !chainMode;

  always_comb begin
    next_state      = state;
    next_convCnt    = convCnt;
    next_shReg      = shReg;
    next_bitsLeft   = bitsLeft;
    next_chainMode  = chainMode;
    next_busyEnable = busyEnable;
    fifoPop         = 1'b0;
    if (startConv) begin
      // level just before the edge, so a tied select reads low
      next_chainMode  = !pinPrev.serialInSelect;
      next_busyEnable = !pinPrev.serialInSelect &&
                        pinLvl.serialClk;
      next_convCnt    = CONV_LEN - 1'b1;
      next_state      = S_CONV;
    end else begin
      case (state)
        S_CONV: begin
          if (convCnt != RST_CONV_CNT) begin
            next_convCnt = convCnt - 1'b1;
          end else if (fifoValid) begin
            fifoPop = 1'b1;
            if (!chainMode) begin
              next_busyEnable = csBusy;
            end
            if (endBusy) begin
              next_shReg    = {chainMode, saturate(fifoData)};
              next_bitsLeft = BUSY_FRAME_BITS;
              next_state    = S_SHIFT;
            end else begin
              next_shReg    = {saturate(fifoData), 1'b0};
              next_bitsLeft = FRAME_BITS;
              next_state    = chainMode ? S_SHIFT : S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (readSelect) begin
            next_state = S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (sdiRise) begin
            next_state = S_IDLE;
          end else if (sclkFall) begin
            next_shReg = {shReg[SHREG_W-2:0],
                          chainMode && pinLvl.serialInSelect};
            if (!chainMode) begin
              next_bitsLeft = bitsLeft - 1'b1;
              if (bitsLeft == LAST_BIT) begin
                next_state = S_IDLE;
              end
            end
          end
        end
        S_IDLE: begin
          next_state = S_IDLE;
        end
        default: begin
          next_state = S_IDLE;
        end
      endcase
    end
    // outputs follow the next state so they line up with it
    next_sdoPin.serialResultOut = next_shReg[SHREG_W-1];
    next_sdoPin.serialResultOeN = (next_state != S_SHIFT);
    next_powerDown              = (next_state != S_CONV);
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state      <= S_IDLE;
      convCnt    <= RST_CONV_CNT;
      shReg      <= RST_SHREG;
      bitsLeft   <= RST_BITS;
      chainMode  <= 1'b0;
      busyEnable <= 1'b0;
      sdoPin     <= '{serialResultOut: 1'b0, serialResultOeN: 1'b1};
      powerDown  <= 1'b1;
    end else begin
      state      <= next_state;
      convCnt    <= next_convCnt;
      shReg      <= next_shReg;
      bitsLeft   <= next_bitsLeft;
      chainMode  <= next_chainMode;
      busyEnable <= next_busyEnable;
      sdoPin     <= next_sdoPin;
      powerDown  <= next_powerDown;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_mode_select: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    startConv |=> chainMode == !$past(pinPrev.serialInSelect))
    else $error("mode not taken from select level");

  a_tied_chain: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (startConv && pinLvl.serialInSelect && !pinPrev.serialInSelect)
    |=> chainMode)
    else $error("tied select did not give chain mode");

  a_chain_busy: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (startConv && !pinPrev.serialInSelect)
    |=> busyEnable == $past(pinLvl.serialClk))
    else $error("chain busy not taken from serial clock");

  a_start_release: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (startConv && pinPrev.serialInSelect)
    |=> !chainMode && sdoPin.serialResultOeN && state == S_CONV)
    else $error("conversion start did not release output");

  a_conv_runs: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (state == S_CONV && convCnt != RST_CONV_CNT) |=> state == S_CONV)
    else $error("conversion cut short");

  a_conv_hiz: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    state == S_CONV |-> sdoPin.serialResultOeN && !powerDown)
    else $error("output driven during conversion");

  a_busy_low: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (state == S_CONV && fifoPop && !chainMode && csBusy)
    |=> !sdoPin.serialResultOeN && !sdoPin.serialResultOut
        && bitsLeft == BUSY_FRAME_BITS)
    else $error("busy start bit not driven low");

  a_frame_end: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (state == S_SHIFT && !chainMode && !startConv && !sdiRise
     && sclkFall && bitsLeft == LAST_BIT)
    |=> sdoPin.serialResultOeN && state == S_IDLE)
    else $error("output not released after last fall");

  a_strobe_release: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (state == S_SHIFT && startConv) |=> sdoPin.serialResultOeN)
    else $error("strobe rise did not release output");

  a_bit_stable: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (state == S_SHIFT && !sclkFall && !startConv && !sdiRise)
    |=> $stable(sdoPin.serialResultOut))
    else $error("output bit moved without a falling clock");

  a_shift_order: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (state == S_SHIFT && sclkFall && !startConv && !sdiRise
     && (chainMode || bitsLeft != LAST_BIT))
    |=> sdoPin.serialResultOut == $past(shReg[SHREG_W-2]))
    else $error("next bit not shifted out");

  a_power_down: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    (state == S_CONV && fifoPop) |=> powerDown && state != S_CONV)
    else $error("no power down after conversion");

endmodule

// ---- testbench/adcsr_host_model.sv ----
// host model driving the serial pins and reading result frames
`timescale 1ns/1ns
module adcsr_host_model
  import adcsr_pkg::*;
(
  // clock
  input  logic           sys_clk,
  // serial pins
  input  adcsr_sdo_type  sdoPin,
  output adcsr_pins_type pinIn
);
  // ----------------------------------------------------------------
  // pin drivers and frame reader
  // ----------------------------------------------------------------
  logic strobe = 1'b0;
  logic sclk   = 1'b0;
  logic sel    = 1'b1;
  logic sdoWire;

  assign pinIn = '{strobe, sclk, sel};
  // pull-up while the output is released
  assign sdoWire = sdoPin.serialResultOeN ? 1'b1 : sdoPin.serialResultOut;

  task automatic setp(input logic s, input logic c, input logic d);
    @(posedge sys_clk);
    strobe <= s;
    sclk   <= c;
    sel    <= d;
  endtask

  // serial clock runs only inside a frame, 6 cycles each half
  task automatic read_frame(input int nb, output logic [RESULT_W:0] got,
                            output int bad);
    logic a;
    got = '0;
    bad = 0;
    for (int i = 0; i < nb; i++) begin
      repeat (6) @(posedge sys_clk);
      a = sdoWire;
      sclk <= 1'b1;
      repeat (6) @(posedge sys_clk);
      if (a !== sdoWire) bad++;
      got = {got[RESULT_W-1:0], sdoWire};
      sclk <= 1'b0;
    end
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench of the serial readout block
`timescale 1ns/1ns
module tb_top
  import adcsr_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int CONV = 250;
  logic             sys_clk = 1'b0;
  logic             nrst = 1'b0;
  adcsr_pins_type   pinIn;
  adcsr_sdo_type    sdoPin;
  logic [RAW_W-1:0] sampleData = '0;
  logic             sampleValid = 1'b0;
  logic             sampleReady;
  logic             powerDown;
  logic             chainMode;
  logic             busyEnable;
  int               n_fail = 0;
  int               n_checks = 0;
  int               cyc = 0;
  logic [RAW_W-1:0] words [6] = '{20'h3ffff, 20'h80000, 20'h12345,
                                  20'hfffff, 20'h00001, 20'h1ffff};

  always #2 sys_clk = ~sys_clk;

  adcsr_top #(.CONV_CYCLES(CONV), .DEPTH(FIFO_DEPTH)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .pinIn(pinIn), .sdoPin(sdoPin),
    .sampleData(sampleData), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .powerDown(powerDown),
    .chainMode(chainMode), .busyEnable(busyEnable));

  adcsr_host_model host (.sys_clk(sys_clk), .sdoPin(sdoPin), .pinIn(pinIn));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [RESULT_W-1:0] sat(input logic [RAW_W-1:0] r);
    if ($signed(r) > RAW_POS_LIMIT) return SAT_POS_CODE;
    if ($signed(r) < RAW_NEG_LIMIT) return SAT_NEG_CODE;
    return r[RESULT_W-1:0];
  endfunction

  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("ERROR %0t run did not finish", $time);
      conclude();
    end
  end

  task automatic push1(input int k);
    @(posedge sys_clk);
    sampleData  <= words[k];
    sampleValid <= 1'b1;
    @(posedge sys_clk);
    sampleValid <= 1'b0;
  endtask

  task automatic start_conv(input logic s0, input logic s1, input logic c);
    host.setp(1'b0, c, s0);
    tick(4);
    host.setp(1'b1, c, s1);
  endtask

  task automatic wait_done(input int pre);
    int  n;
    bit  oeBad;
    n = pre;
    oeBad = 0;
    while (powerDown !== 1'b0 && n < 10) begin
      tick(1);
      n++;
    end
    while (powerDown !== 1'b1 && n < 1000) begin
      if (sdoPin.serialResultOeN !== 1'b1) oeBad = 1;
      tick(1);
      n++;
    end
    chk(!oeBad, "output driven during conversion");
    chk(n >= CONV && n <= CONV + 8,
        "conversion length wrong");
    tick(3);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sel_read(input int k, input int nb);
    logic [RESULT_W-1:0] e;
    logic [RESULT_W:0]   got;
    int                  bad;
    e = sat(words[k]);
    chk(chainMode === 1'b0 && busyEnable === 1'b0 && powerDown === 1'b1 &&
        sdoPin.serialResultOeN === 1'b1,
        "select mode idle wrong");
    host.setp(1'b0, 1'b0, 1'b1);
    tick(5);
    chk(sdoPin.serialResultOeN === 1'b0 &&
        sdoPin.serialResultOut === e[17], "msb not shown");
    host.read_frame(nb, got, bad);
    chk(got === ({1'b0, e} >> (18 - nb)) && bad == 0,
        "frame bits");
    if (nb == 18) chk(sdoPin.serialResultOeN === 1'b1, "not released");
  endtask

  task automatic t_sel_nobusy;
    start_conv(1'b1, 1'b1, 1'b0);
    tick(20);
    host.setp(1'b0, 1'b0, 1'b1);
    tick(8);
    host.setp(1'b1, 1'b0, 1'b1);
    wait_done(30);
    sel_read(0, 18);
  endtask

  task automatic busy_frame(input int k, input logic sb, input logic ch);
    logic [RESULT_W:0] got;
    int                bad;
    chk(chainMode === ch && busyEnable === 1'b1 &&
        sdoPin.serialResultOeN === 1'b0 &&
        sdoPin.serialResultOut === sb, "start bit wrong");
    host.read_frame(19, got, bad);
    chk(got === {sb, sat(words[k])} && bad == 0,
        "busy frame bits");
  endtask

  task automatic t_sel_busy;
    start_conv(1'b1, 1'b1, 1'b0);
    tick(20);
    host.setp(1'b0, 1'b0, 1'b1);
    wait_done(21);
    busy_frame(1, 1'b0, 1'b0);
    chk(sdoPin.serialResultOeN === 1'b1, "busy frame not released");
  endtask

  task automatic t_chain_tied;
    logic [RESULT_W-1:0] e;
    logic [RESULT_W:0]   got;
    int                  bad;
    e = sat(words[2]);
    start_conv(1'b0, 1'b1, 1'b0);
    wait_done(0);
    chk(chainMode === 1'b1 && busyEnable === 1'b0 &&
        sdoPin.serialResultOeN === 1'b0 &&
        sdoPin.serialResultOut === e[17],
        "chain start wrong");
    host.read_frame(18, got, bad);
    chk(got[RESULT_W-1:0] === e && bad == 0, "chain bits");
  endtask

  task automatic t_chain_busy;
    start_conv(1'b0, 1'b0, 1'b1);
    tick(5);
    host.setp(1'b1, 1'b0, 1'b0);
    wait_done(6);
    busy_frame(3, 1'b1, 1'b1);
  endtask

  task automatic t_abort;
    start_conv(1'b1, 1'b1, 1'b0);
    wait_done(0);
    sel_read(4, 5);
    host.setp(1'b1, 1'b0, 1'b1);
    tick(4);
    chk(sdoPin.serialResultOeN === 1'b1 && powerDown === 1'b0,
        "strobe rise did not abort");
    wait_done(5);
    sel_read(5, 18);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(sdoPin.serialResultOeN === 1'b1 && powerDown === 1'b1 &&
        chainMode === 1'b0 && busyEnable === 1'b0 &&
        sampleReady === 1'b1, "reset values");
    @(posedge sys_clk);
    nrst <= 1'b1;
    tick(4);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      sampleData  <= words[i];
      sampleValid <= 1'b1;
    end
    @(posedge sys_clk);
    sampleData <= 20'h0aaaa;
    @(negedge sys_clk);
    chk(sampleReady === 1'b0, "full fifo still ready");
    tick(3);
    sampleValid <= 1'b0;
    t_sel_nobusy();
    push1(4);
    t_sel_busy();
    push1(5);
    t_chain_tied();
    t_chain_busy();
    t_abort();
    conclude();
  end
endmodule
